// ===== logic/link_crc_error_supervisor.v
`timescale 1ns/1ps
module link_crc_error_supervisor (
    input wire clk_i,
    input wire rst_n_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire init_done_i,
    input wire init_fail_i,
    input wire reset_cmd_i,
    input wire start_link_i,
    input wire sync_ok_i,
    input wire frame_valid_i,
    input wire frame_own_i,
    input wire frame_crc_err_i,
    input wire [31:0] frame_data_i,
    input wire cmd_alarm_clear_i,
    input wire update_count_mismatch_i,
    output reg [31:0] ctrl_data_o,
    output reg ctrl_valid_o,
    output reg [7:0] resp_byte1_o,
    output reg resp_valid_o,
    output reg [7:0] warn_code_o,
    output reg consecutive_crc_warning_o,
    output reg accumulated_crc_warning_o,
    output reg update_count_warning_o,
    output reg hw_error_o,
    output reg [1:0] link_state_o,
    output reg link_status_lamp_o,
    output reg irq_o
);
`include "link_crc_regs.vh"

    // link states, one-hot
    localparam [1:0] ST_INITIAL = 2'h1;
    localparam [1:0] ST_RUNNING = 2'h2;

    // synchroniser stages
    reg rst_s1;
    reg rst_sync;
    reg init_done_s1, init_done_s2;
    reg init_fail_s1, init_fail_s2;
    // software-set limits and enables
    reg [15:0] consecutive_crc_warn_limit;
    reg [15:0] accumulated_crc_warn_limit;
    reg [15:0] warning_enable_attributes;
    // counters, flags and frame memory
    reg [15:0] consec_count;
    reg [15:0] accum_count;
    reg [2:0] irq_status;
    reg [2:0] irq_enable;
    reg [1:0] state;
    reg [1:0] next_state;
    reg checking;
    reg hw_error;
    reg warn_c0, warn_c1, warn_c2;
    reg [31:0] last_good;
    // combinational next values and strobes
    reg [31:0] next_rdata;
    reg [7:0] next_code;
    reg [15:0] next_consec;
    reg [15:0] next_accum;
    wire rx_read;
    wire crc_bad;
    wire consec_en;
    wire accum_en;
    wire frame_clear;
    wire reg_clear;
    wire alarm_clear;
    wire [2:0] irq_events;
    wire [2:0] irq_clear_mask;

    // reset release through two flops; reset command reboots link state, check, counters and warnings like power-up
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync <= rst_s1;
        end
    end

    // status pins from the comm circuit are asynchronous to us
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_done_s1 <= 1'b0;
            init_done_s2 <= 1'b0;
            init_fail_s1 <= 1'b0;
            init_fail_s2 <= 1'b0;
        end else begin
            init_done_s1 <= init_done_i;
            init_done_s2 <= init_done_s1;
            init_fail_s1 <= init_fail_i;
            init_fail_s2 <= init_fail_s1;
        end
    end

    // receive read happens once per cycle, only while running
    assign rx_read = frame_valid_i & frame_own_i & (state == ST_RUNNING);
    assign crc_bad = rx_read & frame_crc_err_i;
    assign consec_en = (consecutive_crc_warn_limit != 16'h0000)
        & warning_enable_attributes[`ATTR_CONSEC_EN_BIT];
    assign accum_en = (accumulated_crc_warn_limit != 16'h0000)
        & warning_enable_attributes[`ATTR_ACCUM_EN_BIT];
    // alarm clear from a good frame; a bad frame's command bits are not trusted
    assign frame_clear = rx_read & ~frame_crc_err_i & cmd_alarm_clear_i;
    // software path to the same clear, for hosts that use the plain port
    assign reg_clear = wr_i & (addr_i == `ADDR_CONTROL) & wdata_i[`CTRL_ALARM_CLEAR_BIT];
    assign alarm_clear = frame_clear | reg_clear;

    // saturate rather than wrap so a reached limit stays reached
    always @* begin
        next_consec = 16'h0000; // any good read point zeroes the run
        if (crc_bad) begin
            if (consec_count == 16'hFFFF) begin
                next_consec = consec_count;
            end else begin
                next_consec = consec_count + 16'h0001;
            end
        end
    end

    // the running total never falls here, only by a clear or a reboot
    always @* begin
        next_accum = accum_count;
        if (crc_bad && accum_count != 16'hFFFF) begin
            next_accum = accum_count + 16'h0001;
        end
    end

    // link state: hardware error pins it in initial; warnings never move it
    always @* begin
        next_state = state;
        case (state)
            ST_INITIAL: begin
                if (!hw_error && !checking && start_link_i) begin
                    next_state = ST_RUNNING;
                end
            end
            ST_RUNNING: begin
                // only a reboot leaves running; warnings have no path here
                next_state = ST_RUNNING;
            end
            default: begin
                next_state = ST_INITIAL;
            end
        endcase
    end

    // power-up / reset-command check of the comm circuit
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_INITIAL;
            checking <= 1'b1;
            hw_error <= 1'b0;
        end else if (!rst_sync || reset_cmd_i) begin
            state <= ST_INITIAL;
            checking <= 1'b1;
            hw_error <= 1'b0;
        end else begin
            // a later fault is not seen until the next reboot, by design
            if (checking) begin
                if (init_fail_s2) begin
                    hw_error <= 1'b1;
                    checking <= 1'b0;
                end else if (init_done_s2) begin
                    checking <= 1'b0;
                end
            end
            state <= next_state;
        end
    end

    // CRC counting and sticky warnings
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            consec_count <= 16'h0000;
            accum_count <= 16'h0000;
            warn_c0 <= 1'b0;
            warn_c1 <= 1'b0;
            warn_c2 <= 1'b0;
        end else if (!rst_sync || reset_cmd_i) begin
            consec_count <= 16'h0000;
            accum_count <= 16'h0000;
            warn_c0 <= 1'b0;
            warn_c1 <= 1'b0;
            warn_c2 <= 1'b0;
        end else begin
            if (rx_read) begin
                consec_count <= next_consec;
            end
            // accumulated total only falls by a clear while disabled
            if (alarm_clear && !accum_en) begin
                accum_count <= 16'h0000;
            end else begin
                accum_count <= next_accum;
            end
            // set wins over clear; clear only takes once disabled
            if (crc_bad && consec_en && next_consec >= consecutive_crc_warn_limit) begin
                warn_c0 <= 1'b1;
            end else if (alarm_clear && !consec_en) begin
                warn_c0 <= 1'b0;
            end
            if (crc_bad && accum_en && next_accum >= accumulated_crc_warn_limit) begin
                warn_c1 <= 1'b1;
            end else if (alarm_clear && !accum_en) begin
                warn_c1 <= 1'b0;
            end
            if (update_count_mismatch_i && sync_ok_i && state == ST_RUNNING
                && warning_enable_attributes[`ATTR_UPDATE_EN_BIT]) begin
                warn_c2 <= 1'b1;
            end else if (alarm_clear && !warning_enable_attributes[`ATTR_UPDATE_EN_BIT]) begin
                warn_c2 <= 1'b0;
            end
        end
    end

    // frame forwarding: bad frames dropped, last good data reused
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_good <= 32'h00000000;
            ctrl_data_o <= 32'h00000000;
            ctrl_valid_o <= 1'b0;
            resp_byte1_o <= 8'h00;
            resp_valid_o <= 1'b0;
        end else begin
            // data and byte 1 stand until the next read point
            ctrl_valid_o <= rx_read; // cycle timing kept on every read
            resp_valid_o <= rx_read;
            if (rx_read && !frame_crc_err_i) begin
                last_good <= frame_data_i;
                ctrl_data_o <= frame_data_i;
                resp_byte1_o <= 8'h00;
            end else if (crc_bad) begin
                ctrl_data_o <= last_good;
                resp_byte1_o <= `RESP_BYTE1_CRC_BAD;
            end
        end
    end

    // highest-priority active warning code
    always @* begin
        if (warn_c0) begin
            next_code = `WARN_CODE_CONSEC;
        end else if (warn_c1) begin
            next_code = `WARN_CODE_ACCUM;
        end else if (warn_c2) begin
            next_code = `WARN_CODE_UPDATE;
        end else begin
            next_code = `WARN_CODE_NONE;
        end
    end

    // registered outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_code_o <= 8'h00;
            consecutive_crc_warning_o <= 1'b0;
            accumulated_crc_warning_o <= 1'b0;
            update_count_warning_o <= 1'b0;
            hw_error_o <= 1'b0;
            link_state_o <= ST_INITIAL;
            link_status_lamp_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            warn_code_o <= next_code;
            consecutive_crc_warning_o <= warn_c0;
            accumulated_crc_warning_o <= warn_c1;
            update_count_warning_o <= warn_c2;
            hw_error_o <= hw_error;
            link_state_o <= state;
            link_status_lamp_o <= hw_error; // steady red on hardware error
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // rising edges of the internal flags, found against their output copies
    assign irq_events[`IRQ_CONSEC_BIT] = warn_c0 & ~consecutive_crc_warning_o;
    assign irq_events[`IRQ_ACCUM_BIT] = warn_c1 & ~accumulated_crc_warning_o;
    assign irq_events[`IRQ_HWERR_BIT] = hw_error & ~hw_error_o;

    // write-one-to-clear mask, zero outside a clear write
    assign irq_clear_mask = (wr_i && addr_i == `ADDR_IRQ_CLEAR) ? wdata_i[2:0] : 3'h0;

    // register writes and interrupt status
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            consecutive_crc_warn_limit <= `RST_LIMIT;
            accumulated_crc_warn_limit <= `RST_LIMIT;
            warning_enable_attributes <= `RST_ATTR;
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
        end else begin
            if (wr_i && addr_i == `ADDR_CONSEC_LIMIT) begin
                consecutive_crc_warn_limit <= wdata_i[15:0];
            end
            if (wr_i && addr_i == `ADDR_ACCUM_LIMIT) begin
                accumulated_crc_warn_limit <= wdata_i[15:0];
            end
            if (wr_i && addr_i == `ADDR_WARN_ATTR) begin
                warning_enable_attributes <= wdata_i[15:0];
            end
            if (wr_i && addr_i == `ADDR_IRQ_ENABLE) begin
                irq_enable <= wdata_i[2:0];
            end
            // events set, write-one clears; set wins
            irq_status <= (irq_status & ~irq_clear_mask) | irq_events;
        end
    end

    // read mux
    always @* begin
        case (addr_i)
            `ADDR_CONSEC_LIMIT: begin
                next_rdata = {16'h0000, consecutive_crc_warn_limit};
            end
            `ADDR_ACCUM_LIMIT: begin
                next_rdata = {16'h0000, accumulated_crc_warn_limit};
            end
            `ADDR_WARN_ATTR: begin
                next_rdata = {16'h0000, warning_enable_attributes};
            end
            `ADDR_STATUS: begin
                next_rdata = {16'h0000, next_code, 1'b0, hw_error, checking,
                    warn_c2, warn_c1, warn_c0, state};
            end
            `ADDR_IRQ_STATUS: begin
                next_rdata = {29'h00000000, irq_status};
            end
            `ADDR_IRQ_ENABLE: begin
                next_rdata = {29'h00000000, irq_enable};
            end
            `ADDR_COUNTS: begin
                next_rdata = {accum_count, consec_count};
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // read data stands one cycle after the strobe only
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 32'h00000000;
        end
    end

endmodule // link_crc_error_supervisor

// ===== logic/link_crc_regs.vh
`ifndef LINK_CRC_REGS_VH
`define LINK_CRC_REGS_VH
// register indices on the plain port
`define ADDR_CONSEC_LIMIT 4'h0
`define ADDR_ACCUM_LIMIT 4'h1
`define ADDR_WARN_ATTR 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_CLEAR 4'h5
`define ADDR_IRQ_ENABLE 4'h6
`define ADDR_COUNTS 4'h7
`define ADDR_CONTROL 4'h8
// attribute word enable bits
`define ATTR_CONSEC_EN_BIT 9
`define ATTR_ACCUM_EN_BIT 10
`define ATTR_UPDATE_EN_BIT 11
// warning codes
`define WARN_CODE_CONSEC 8'hC0
`define WARN_CODE_ACCUM 8'hC1
`define WARN_CODE_UPDATE 8'hC2
`define WARN_CODE_NONE 8'h00
`define RESP_BYTE1_CRC_BAD 8'hFF
// reset values
`define RST_LIMIT 16'h0000
`define RST_ATTR 16'h0000
// irq status bits
`define IRQ_CONSEC_BIT 0
`define IRQ_ACCUM_BIT 1
`define IRQ_HWERR_BIT 2
// control register bits
`define CTRL_ALARM_CLEAR_BIT 0
`endif

// ===== verif/link_crc_error_supervisor_asserts.sv
`timescale 1ns/1ps
// watches the frame path, warning flags and link state at the top ports
module link_crc_sva (
    input wire clk_i,
    input wire rst_n_i,
    input wire reset_cmd_i,
    input wire frame_valid_i,
    input wire frame_own_i,
    input wire frame_crc_err_i,
    input wire [31:0] frame_data_i,
    input wire [31:0] ctrl_data_o,
    input wire ctrl_valid_o,
    input wire [7:0] resp_byte1_o,
    input wire [7:0] warn_code_o,
    input wire consecutive_crc_warning_o,
    input wire accumulated_crc_warning_o,
    input wire hw_error_o,
    input wire [1:0] link_state_o,
    input wire link_status_lamp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a read point counts only for our node while running
    wire take = frame_valid_i && frame_own_i && link_state_o == 2'b10;
    wire bad = take && frame_crc_err_i;
    chk_bad_byte: assert property (bad |=> resp_byte1_o == 8'hFF)
        else $error("byte 1 not FF after bad frame");
    chk_good_applied: assert property (take && !frame_crc_err_i |=>
        ctrl_data_o == $past(frame_data_i) && resp_byte1_o == 8'h00)
        else $error("good frame not applied");
    chk_bad_dropped: assert property (bad |=> $stable(ctrl_data_o))
        else $error("bad frame data applied");
    chk_valid_pulse: assert property (ctrl_valid_o == $past(take))
        else $error("valid pulse not tied to read point");
    chk_idle_ignored: assert property (frame_valid_i && link_state_o == 2'b01
        |=> !ctrl_valid_o)
        else $error("frame taken while initial");
    chk_run_kept: assert property (link_state_o == 2'b10 && !reset_cmd_i
        && !$past(reset_cmd_i) |=> link_state_o == 2'b10)
        else $error("link left running");
    chk_hw_initial: assert property (hw_error_o |-> link_state_o == 2'b01
        && link_status_lamp_o)
        else $error("hardware error without initial state");
    chk_hw_kept: assert property (hw_error_o && !reset_cmd_i && !$past(reset_cmd_i)
        |=> hw_error_o)
        else $error("hardware error cleared");
    chk_code_c0: assert property (consecutive_crc_warning_o |-> warn_code_o == 8'hC0)
        else $error("code not C0");
    chk_code_c1: assert property (accumulated_crc_warning_o && !consecutive_crc_warning_o
        |-> warn_code_o == 8'hC1)
        else $error("code not C1");
    chk_cmd_reboot: assert property (reset_cmd_i |=> ##1 !consecutive_crc_warning_o
        && !accumulated_crc_warning_o && link_state_o == 2'b01)
        else $error("reset command left warnings");
    cover property (bad);
    cover property ($rose(consecutive_crc_warning_o));
    cover property ($rose(accumulated_crc_warning_o));
    cover property ($rose(hw_error_o));
endmodule // link_crc_sva
bind link_crc_error_supervisor link_crc_sva link_crc_sva_i (.*);

// ===== verif/host_ctrl_model.sv
`timescale 1ns/1ps
// host side: puts one frame on the receive read point per call
module host_ctrl_model (
    input wire clk_i,
    output reg frame_valid_i = 1'b0,
    output reg frame_own_i = 1'b0,
    output reg frame_crc_err_i = 1'b0,
    output reg cmd_alarm_clear_i = 1'b0,
    output reg [31:0] frame_data_i = 32'h0
);
    task send(input o, input e, input c, input [31:0] d);
        begin
            @(posedge clk_i);
            frame_valid_i <= 1'b1;
            frame_own_i <= o;
            frame_crc_err_i <= e;
            cmd_alarm_clear_i <= c;
            frame_data_i <= d;
            @(posedge clk_i);
            frame_valid_i <= 1'b0;
            frame_own_i <= 1'b0;
            frame_crc_err_i <= 1'b0;
            cmd_alarm_clear_i <= 1'b0;
            // stale data inverted so nothing relies on it outside a frame
            frame_data_i <= ~d;
        end
    endtask
endmodule // host_ctrl_model

// ===== verif/link_crc_error_supervisor_test.sv
`timescale 1ns/1ps
module link_crc_error_supervisor_test;
`include "link_crc_regs.vh"
    reg clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, init_fail_i = 0, reset_cmd_i = 0;
    reg start_link_i = 0, init_done_i = 1, sync_ok_i = 1, update_count_mismatch_i = 0;
    reg [3:0] addr_i = 0;
    reg [31:0] wdata_i = 0;
    wire frame_valid_i, frame_own_i, frame_crc_err_i, cmd_alarm_clear_i;
    wire [31:0] frame_data_i, rdata_o, ctrl_data_o;
    wire [7:0] resp_byte1_o, warn_code_o;
    wire ctrl_valid_o, resp_valid_o, consecutive_crc_warning_o, accumulated_crc_warning_o;
    wire update_count_warning_o, hw_error_o, link_status_lamp_o, irq_o;
    wire [1:0] link_state_o;
    integer failures = 0, n_compared = 0, cyc = 0, consec = 0, accum = 0, lim0, lim1, i;
    reg w0 = 0, w1 = 0, e0, e1;
    reg [1:0] st = 0, en = 0;
    reg [15:0] rnd = 16'h004B;
    reg [31:0] last = 0;
    link_crc_error_supervisor link_crc_error_supervisor_i (.*);
    host_ctrl_model host_ctrl_model_i (.*);
    always #2.5 clk_i = ~clk_i;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task tally_and_finish;
        begin
            if (failures == 0 && n_compared > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1;
            @(posedge clk_i);
            wr_i <= 0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1;
            @(posedge clk_i);
            rd_i <= 0;
            #1 chk("rdata", e, rdata_o);
        end
    endtask
    task cfg(input integer l0, input integer l1, input [1:0] a);
        begin
            wr(`ADDR_CONSEC_LIMIT, l0);
            wr(`ADDR_ACCUM_LIMIT, l1);
            wr(`ADDR_WARN_ATTR, {21'h0, a, 9'h0});
            lim0 = l0;
            lim1 = l1;
            {e1, e0} = a;
        end
    endtask
    task pulse;
        begin
            @(posedge clk_i);
            reset_cmd_i <= 1;
            @(posedge clk_i);
            reset_cmd_i <= 0;
        end
    endtask
    // one frame, then the model update and every result it causes
    task frm(input o, input e, input c);
        reg [31:0] d;
        reg p0, p1;
        begin
            rnd = lfsr(rnd);
            d = {rnd, ~rnd};
            {p1, p0} = {w1, w0};
            host_ctrl_model_i.send(o, e, c, d);
            if (o && e) begin
                consec = consec + 1;
                accum = accum + 1;
                if (e0 && lim0 != 0 && consec >= lim0) w0 = 1;
                if (e1 && lim1 != 0 && accum >= lim1) w1 = 1;
            end else if (o) begin
                consec = 0;
                last = d;
                if (c && !(e0 && lim0 != 0)) w0 = 0;
                if (c && !(e1 && lim1 != 0)) begin
                    w1 = 0;
                    accum = 0;
                end
            end
            st = st | {w1 & !p1, w0 & !p0};
            #1 chk("valid", o, ctrl_valid_o);
            chk("data", last, ctrl_data_o);
            if (o) chk("byte1", e ? 8'hFF : 8'h00, resp_byte1_o);
            chk("rvld", o, resp_valid_o);
            @(posedge clk_i);
            #1 chk("c0", w0, consecutive_crc_warning_o);
            chk("c1", w1, accumulated_crc_warning_o);
            chk("code", w0 ? 8'hC0 : w1 ? 8'hC1 : 8'h00, warn_code_o);
            chk("state", 2'b10, link_state_o);
            @(posedge clk_i);
            #1 chk("irq", |(st & en), irq_o);
            rd(`ADDR_COUNTS, {accum[15:0], consec[15:0]});
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1;
        rd(`ADDR_CONSEC_LIMIT, 0);
        rd(`ADDR_WARN_ATTR, 0);
        rd(4'hF, 0);
        start_link_i <= 1;
        cfg(3, 5, 3);
        wr(`ADDR_IRQ_ENABLE, 3);
        en = 3;
        for (i = 0; i < 50 && link_state_o !== 2'b10; i = i + 1) @(posedge clk_i);
        // random errors, foreign frames and refused clears while enabled
        for (i = 0; i < 40; i = i + 1) frm(rnd[3:0] != 0, rnd[5] | rnd[6], rnd[8] & rnd[9]);
        wr(`ADDR_IRQ_ENABLE, 0);
        en = 0;
        repeat (2) @(posedge clk_i);
        #1 chk("irq", 0, irq_o);
        rd(`ADDR_IRQ_STATUS, st);
        wr(`ADDR_IRQ_CLEAR, 3);
        st = 0;
        rd(`ADDR_IRQ_STATUS, 0);
        wr(`ADDR_IRQ_ENABLE, 3);
        en = 3;
        // update-counter warning while running and synchronised
        wr(`ADDR_WARN_ATTR, 32'h00000E00);
        @(posedge clk_i);
        update_count_mismatch_i <= 1;
        @(posedge clk_i);
        update_count_mismatch_i <= 0;
        @(posedge clk_i);
        #1 chk("c2", 1, update_count_warning_o);
        // disable first, then alarm clear from a good frame
        cfg(3, 5, 0);
        frm(1, 0, 1);
        chk("c2", 0, update_count_warning_o);
        // limit zero, then enable bit clear, each keeps warnings off
        for (i = 0; i < 2; i = i + 1) begin
            cfg(i ? 2 : 0, i ? 2 : 0, i ? 0 : 3);
            repeat (3) frm(1, 1, 0);
        end
        cfg(2, 2, 3);
        repeat (2) frm(1, 1, 0);
        start_link_i <= 0;
        pulse;
        @(posedge clk_i);
        #1 chk("c0", 0, consecutive_crc_warning_o);
        chk("c1", 0, accumulated_crc_warning_o);
        host_ctrl_model_i.send(1, 1, 0, 32'h0);
        #1 chk("valid", 0, ctrl_valid_o);
        init_fail_i <= 1;
        repeat (6) @(posedge clk_i);
        #1 chk("hw", 0, hw_error_o);
        start_link_i <= 1;
        pulse;
        repeat (8) @(posedge clk_i);
        wr(`ADDR_CONTROL, 1);
        wr(`ADDR_IRQ_ENABLE, 4);
        repeat (3) @(posedge clk_i);
        #1 chk("hw", 1, hw_error_o);
        chk("lamp", 1, link_status_lamp_o);
        chk("state", 2'b01, link_state_o);
        chk("irq", 1, irq_o);
        tally_and_finish;
    end
endmodule // link_crc_error_supervisor_test
